// file: src/status_led_strap_pins.sv
/*
 * Status LED and start-up strap pins with an AHB-Lite register slave.
 * Two shared pins are strap inputs during their start-up windows and
 * active-low LED outputs afterwards; a blue LED flashes on traffic.
 * Assumes pins are synchronous to clk_i and undriven pins read high
 * through the pad pull-ups enabled by pullup_en_o.
 */
// The implementer's own choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - red/mode pin drives active-low red LED, meaningful from 600 ms after power-up
// - red/mode pin is an input for the first 600 ms, then red LED output
// - mode strap is active low and weakly pulled up when undriven
// - connect switch input is weakly pulled up; low requests connect
// - connect switch and serial-default strap both low at start-up restores factory settings
// - green/strap pin drives active-low green LED, meaningful from 500 ms after power-up
// - serial-default strap is sampled only in the first 500 ms, then green LED
// - serial-default strap low in its window reverts serial port to default settings
// - serial-default strap is active low and weakly pulled up when undriven
// - blue traffic LED is active low and flashes while data moves
// - clear-to-send input is active low; low permits transmission
// - request-to-send output is active low; low invites the host to send
module status_led_strap_pins #(
    parameter int CYC_PER_MS = strap_led_pkg::CYC_PER_MS
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    // ahb-lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic hready_i,
    input wire logic [31:0] hwdata_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // shared red led / mode strap pin
    input wire logic red_mode_n_i,
    output logic red_mode_n_o,
    output logic red_mode_oe_o,
    // shared green led / serial-default strap pin
    input wire logic green_sw1_n_i,
    output logic green_sw1_n_o,
    output logic green_sw1_oe_o,
    // connect switch, blue led, uart handshake
    input wire logic switch0_n_i,
    output logic blue_n_o,
    input wire logic cts_n_i,
    output logic rts_n_o,
    output logic pullup_en_o,
    // core side
    input wire logic traffic_i,
    output logic tx_permit_o,
    output logic connect_req_o,
    output logic serial_default_o,
    output logic factory_restore_o,
    output logic mode_strap_o,
    output logic startup_done_o
);

    typedef enum logic [2:0] {
        PH_BOTH = 3'b001,
        PH_MODE = 3'b010,
        PH_RUN = 3'b100
    } phase_e;

    localparam int MS_W = strap_led_pkg::MS_CNT_W;

    // window ends and the saturation point all compare the same counter
    function automatic logic ms_at(input logic [MS_W-1:0] cnt, input int ms);
        return (cnt == MS_W'(ms));
    endfunction : ms_at

    phase_e phase_reg;
    phase_e phase_next;
    logic ms_tick_w;
    logic [MS_W-1:0] ms_cnt_reg;
    logic [MS_W-1:0] blink_cnt_reg;
    logic [MS_W-1:0] act_cnt_reg;
    logic blink_ph_reg;
    logic sw0_prev_reg;
    logic [strap_led_pkg::CTRL_W-1:0] ctrl_reg;
    logic [strap_led_pkg::CTRL_W-1:0] ctrl_next;
    logic [strap_led_pkg::EV_W-1:0] ev_reg;
    logic [strap_led_pkg::EV_W-1:0] ev_next;
    logic wr_pend_reg;
    logic [strap_led_pkg::ADDR_W-1:0] wr_addr_reg;

    ms_tick #(
        .CYC_PER_MS(CYC_PER_MS)
    ) u_tick (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .tick_o(ms_tick_w)
    );

    // start-up windows
    wire green_end = (phase_reg == PH_BOTH) &&
        ms_at(ms_cnt_reg, strap_led_pkg::GREEN_WIN_MS);
    wire mode_end = (phase_reg == PH_MODE) &&
        ms_at(ms_cnt_reg, strap_led_pkg::MODE_WIN_MS);
    wire in_run = (phase_reg == PH_RUN);
    // the counter parks at the last mark so a wrap can never reopen a window
    wire ms_sat = ms_at(ms_cnt_reg, strap_led_pkg::MODE_WIN_MS);

    always_comb begin
        phase_next = phase_reg;
        unique case (phase_reg)
            PH_BOTH: begin
                if (green_end) begin
                    phase_next = PH_MODE;
                end
            end
            PH_MODE: begin
                if (mode_end) begin
                    phase_next = PH_RUN;
                end
            end
            PH_RUN: begin
                phase_next = PH_RUN;
            end
            default: begin
                phase_next = PH_BOTH;
            end
        endcase
    end

    // strap decodes
    wire sw0_low = strap_led_pkg::is_low(switch0_n_i);
    wire sw1_low = strap_led_pkg::is_low(green_sw1_n_i);
    wire restore_hit = green_end && sw0_low && sw1_low;

    // shared pins; led meaning starts when the pin turns to an output
    strap_led_pin u_green (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .capture_i(green_end),
        .led_on_i(ctrl_reg[strap_led_pkg::CTRL_GREEN]),
        .pin_i(green_sw1_n_i),
        .pin_o(green_sw1_n_o),
        .pin_oe_o(green_sw1_oe_o),
        .strap_active_o(serial_default_o)
    );

    strap_led_pin u_red (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .capture_i(mode_end),
        .led_on_i(ctrl_reg[strap_led_pkg::CTRL_RED]),
        .pin_i(red_mode_n_i),
        .pin_o(red_mode_n_o),
        .pin_oe_o(red_mode_oe_o),
        .strap_active_o(mode_strap_o)
    );

    // blue traffic led: activity holds the blink alive for a while
    wire blink_wrap = ms_tick_w &&
        (blink_cnt_reg == MS_W'(strap_led_pkg::BLINK_MS - 1));
    wire act_live = (act_cnt_reg != '0);
    wire blue_on = ctrl_reg[strap_led_pkg::CTRL_BLUE] ||
        (act_live && blink_ph_reg);

    // ahb-lite decode
    wire addr_ok = (haddr_i[1:0] == strap_led_pkg::ALIGN_ZERO) &&
        (hsize_i == strap_led_pkg::HSIZE_WORD) &&
        (haddr_i[31:strap_led_pkg::ADDR_W] == '0);
    wire ahb_valid = hsel_i && htrans_i[1] && hready_i && addr_ok;
    wire rd_req = ahb_valid && !hwrite_i;
    wire [strap_led_pkg::ADDR_W-1:0] a = haddr_i[strap_led_pkg::ADDR_W-1:0];

    wire [strap_led_pkg::STATUS_W-1:0] status_w;
    assign status_w[strap_led_pkg::ST_GREEN_DONE] = green_sw1_oe_o;
    assign status_w[strap_led_pkg::ST_MODE_DONE] = red_mode_oe_o;
    assign status_w[strap_led_pkg::ST_MODE] = mode_strap_o;
    assign status_w[strap_led_pkg::ST_SERDEF] = serial_default_o;
    assign status_w[strap_led_pkg::ST_SWITCH0] = sw0_low;
    assign status_w[strap_led_pkg::ST_CTS] = tx_permit_o;
    assign status_w[strap_led_pkg::ST_RESTORE] = factory_restore_o;

    wire [31:0] rd_word =
        (a == strap_led_pkg::CTRL_OFS) ? 32'(ctrl_reg) :
        (a == strap_led_pkg::STATUS_OFS) ? 32'(status_w) :
        (a == strap_led_pkg::EVENT_OFS) ? 32'(ev_reg) : 32'h0;

    wire wr_ctrl = wr_pend_reg && (wr_addr_reg == strap_led_pkg::CTRL_OFS);
    wire wr_ev = wr_pend_reg && (wr_addr_reg == strap_led_pkg::EVENT_OFS);
    wire [strap_led_pkg::EV_W-1:0] ev_clr =
        wr_ev ? hwdata_i[strap_led_pkg::EV_W-1:0] : '0;

    // events: a set in the clearing cycle wins
    wire [strap_led_pkg::EV_W-1:0] ev_set = {
        in_run && sw0_low && !sw0_prev_reg,
        green_end && sw1_low,
        restore_hit
    };

    assign ev_next = (ev_reg & ~ev_clr) | ev_set;
    assign ctrl_next = wr_ctrl ? hwdata_i[strap_led_pkg::CTRL_W-1:0] : ctrl_reg;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            phase_reg <= PH_BOTH;
            ms_cnt_reg <= '0;
        end else begin
            phase_reg <= phase_next;
            if (ms_tick_w && !ms_sat) begin
                ms_cnt_reg <= ms_cnt_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            blink_cnt_reg <= '0;
            blink_ph_reg <= 1'b0;
            act_cnt_reg <= '0;
        end else begin
            if (ms_tick_w) begin
                blink_cnt_reg <= blink_wrap ? '0 : blink_cnt_reg + 1'b1;
            end
            if (blink_wrap) begin
                blink_ph_reg <= ~blink_ph_reg;
            end
            if (traffic_i) begin
                act_cnt_reg <= MS_W'(strap_led_pkg::ACT_HOLD_MS);
            end else if (ms_tick_w && act_live) begin
                act_cnt_reg <= act_cnt_reg - 1'b1;
            end
        end
    end

    // led and handshake outputs; cts is taken as already synchronous, one stage only
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            blue_n_o <= 1'b1;
            rts_n_o <= 1'b1;
            tx_permit_o <= 1'b0;
        end else begin
            blue_n_o <= ~blue_on;
            rts_n_o <= ~ctrl_reg[strap_led_pkg::CTRL_RTS];
            tx_permit_o <= strap_led_pkg::is_low(cts_n_i);
        end
    end

    // start-up results; restore stays set until the next power-up reset
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            connect_req_o <= 1'b0;
            factory_restore_o <= 1'b0;
            startup_done_o <= 1'b0;
            pullup_en_o <= 1'b1;
            sw0_prev_reg <= 1'b0;
        end else begin
            connect_req_o <= in_run && sw0_low;
            if (restore_hit) begin
                factory_restore_o <= 1'b1;
            end
            startup_done_o <= in_run;
            // pull-ups stay on after the windows, since switch0 remains an input
            pullup_en_o <= 1'b1;
            sw0_prev_reg <= sw0_low;
        end
    end

    // software registers
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl_reg <= strap_led_pkg::CTRL_RESET;
            ev_reg <= strap_led_pkg::EV_RESET;
        end else begin
            ctrl_reg <= ctrl_next;
            ev_reg <= ev_next;
        end
    end

    // bus slave; zero wait states, always OKAY. write data lags its address by a
    // cycle, so the address phase is parked until the data phase arrives
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= '0;
            hrdata_o <= 32'h0;
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end else begin
            wr_pend_reg <= ahb_valid && hwrite_i;
            wr_addr_reg <= a;
            if (rd_req) begin
                hrdata_o <= rd_word;
            end
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end
    end

endmodule : status_led_strap_pins

`default_nettype wire

// file: include/strap_led_pkg.sv
/*
 * Shared constants for the status LED and strap pin block: clock timing,
 * strap windows, LED blink timing, register offsets and field positions.
 * Assumes a single 10 MHz clock and 32-bit AHB-Lite register access.
 */
package strap_led_pkg;

    // clock and timebase
    localparam int CLK_PERIOD_NS = 100;
    localparam int MS_NS = 1000000;
    localparam int CYC_PER_MS = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // strap windows and blue LED timing in milliseconds, and the millisecond counter width in bits
    localparam int GREEN_WIN_MS = 500;
    localparam int MODE_WIN_MS = 600;
    localparam int BLINK_MS = 50;
    localparam int ACT_HOLD_MS = 100;
    localparam int MS_CNT_W = 10;

    // register map, byte addresses
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] EVENT_OFS = 8'h08;

    // control fields
    localparam int CTRL_W = 4;
    localparam int CTRL_RED = 0;
    localparam int CTRL_GREEN = 1;
    localparam int CTRL_BLUE = 2;
    localparam int CTRL_RTS = 3;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h0;

    // status fields
    localparam int STATUS_W = 7;
    localparam int ST_GREEN_DONE = 0;
    localparam int ST_MODE_DONE = 1;
    localparam int ST_MODE = 2;
    localparam int ST_SERDEF = 3;
    localparam int ST_SWITCH0 = 4;
    localparam int ST_CTS = 5;
    localparam int ST_RESTORE = 6;

    // event fields, write one to clear
    localparam int EV_W = 3;
    localparam int EV_RESTORE = 0;
    localparam int EV_SERDEF = 1;
    localparam int EV_CONNECT = 2;
    localparam logic [EV_W-1:0] EV_RESET = 3'h0;

    // bus encodings
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic [1:0] ALIGN_ZERO = 2'h0;

    // every strap, switch and handshake pin is active low
    function automatic logic is_low(input logic lvl);
        return ~lvl;
    endfunction : is_low

endpackage : strap_led_pkg

// file: src/ms_tick.sv
/*
 * Millisecond timebase: one-cycle pulse every CYC_PER_MS clocks.
 * Assumes a free-running clock; the count is a parameter so benches can shorten it.
 */
`timescale 1ns/1ps
`default_nettype none

module ms_tick #(
    parameter int CYC_PER_MS = strap_led_pkg::CYC_PER_MS
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    output logic tick_o
);

    localparam int W = $clog2(CYC_PER_MS + 1);

    logic [W-1:0] cnt_reg;
    wire last = (cnt_reg == W'(CYC_PER_MS - 1));

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_reg <= '0;
            tick_o <= 1'b0;
        end else begin
            cnt_reg <= last ? '0 : cnt_reg + 1'b1;
            tick_o <= last;
        end
    end

endmodule : ms_tick

`default_nettype wire

// file: src/strap_led_pin.sv
/*
 * One shared strap/LED pin: released while the strap is sampled, captured
 * once on capture_i, then driven as an active-low LED output.
 * Assumes capture_i pulses exactly once after reset.
 */
`timescale 1ns/1ps
`default_nettype none

module strap_led_pin (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic capture_i,
    input wire logic led_on_i,
    input wire logic pin_i,
    output logic pin_o,
    output logic pin_oe_o,
    output logic strap_active_o
);

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pin_oe_o <= 1'b0;
            pin_o <= 1'b1;
            strap_active_o <= 1'b0;
        end else begin
            if (capture_i) begin
                strap_active_o <= strap_led_pkg::is_low(pin_i);
                pin_oe_o <= 1'b1;
            end
            pin_o <= ~led_on_i;
        end
    end

endmodule : strap_led_pin

`default_nettype wire

// file: sim/status_led_strap_pins_asserts.sv
/* checker for the strap/LED block, seeing only its top-level ports.
   assumes one clock domain and is bound to every status_led_strap_pins. */
`timescale 1ns/1ps
`default_nettype none
module status_led_strap_pins_asserts #(
    parameter int CYC_PER_MS = 10
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic cts_n_i,
    input wire logic green_sw1_oe_o,
    input wire logic red_mode_oe_o,
    input wire logic tx_permit_o,
    input wire logic connect_req_o,
    input wire logic serial_default_o,
    input wire logic factory_restore_o,
    input wire logic mode_strap_o,
    input wire logic pullup_en_o,
    input wire logic startup_done_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    property p_green_hold; green_sw1_oe_o |=> green_sw1_oe_o; endproperty
    a_green_hold: assert property (p_green_hold) else $error("green oe fell");
    property p_order; red_mode_oe_o |-> $past(green_sw1_oe_o, 8); endproperty
    a_order: assert property (p_order) else $error("red oe before green");
    property p_done; $rose(red_mode_oe_o) |=> startup_done_o; endproperty
    a_done: assert property (p_done) else $error("startup done late");
    property p_cts; $past(rstn_i) |-> tx_permit_o == !$past(cts_n_i); endproperty
    a_cts: assert property (p_cts) else $error("tx permit wrong");
    property p_connect; connect_req_o |-> startup_done_o; endproperty
    a_connect: assert property (p_connect) else $error("connect too early");
    property p_restore; factory_restore_o |=> factory_restore_o; endproperty
    a_restore: assert property (p_restore) else $error("restore dropped");
    property p_serdef; green_sw1_oe_o |=> $stable(serial_default_o); endproperty
    a_serdef: assert property (p_serdef) else $error("serial default moved");
    property p_mode; red_mode_oe_o |=> $stable(mode_strap_o); endproperty
    a_mode: assert property (p_mode) else $error("mode strap moved");
    property p_pullup; pullup_en_o; endproperty
    a_pullup: assert property (p_pullup) else $error("pull-ups off");
endmodule : status_led_strap_pins_asserts
bind status_led_strap_pins status_led_strap_pins_asserts #(.CYC_PER_MS(CYC_PER_MS)) u_chk (
    .clk_i, .rstn_i, .cts_n_i, .green_sw1_oe_o, .red_mode_oe_o, .tx_permit_o, .connect_req_o,
    .serial_default_o, .factory_restore_o, .mode_strap_o, .pullup_en_o, .startup_done_o);
`default_nettype wire

// file: sim/host_board.sv
/* host board model: strap switches on the two shared pins.
   assumes weak pad pull-ups, so a released line reads high. */
`timescale 1ns/1ps
`default_nettype none
module host_board (
    input wire logic grn_low_i,
    input wire logic mode_low_i,
    input wire logic dev_grn_i,
    input wire logic dev_grn_oe_i,
    input wire logic dev_red_i,
    input wire logic dev_red_oe_i,
    output logic grn_pad_o,
    output logic red_pad_o
);
    // switches let go once the device takes the pin, so the LED is never fought
    wire logic host_grn = grn_low_i && !dev_grn_oe_i;
    wire logic host_red = mode_low_i && !dev_red_oe_i;
    assign grn_pad_o = dev_grn_oe_i ? dev_grn_i : !host_grn;
    assign red_pad_o = dev_red_oe_i ? dev_red_i : !host_red;
endmodule : host_board
`default_nettype wire

// file: sim/status_led_strap_pins_bench.sv
/* self-checking bench: host board model, AHB-Lite master, queued read checks.
   assumes CYC_PER_MS shortened to MS cycles. */
`timescale 1ns/1ps
`default_nettype none
module status_led_strap_pins_bench;
    localparam int MS = 10;
    localparam logic [31:0] CTRL_A = 32'(strap_led_pkg::CTRL_OFS);
    localparam logic [31:0] STAT_A = 32'(strap_led_pkg::STATUS_OFS);
    localparam logic [31:0] EV_A = 32'(strap_led_pkg::EVENT_OFS);
    logic clk_i = '0, rstn_i = '0, hsel_i = '0, hwrite_i = '0, traffic_i = '0, rd_dph = '0;
    logic switch0_n_i = '0, cts_n_i = '1, grn_low = '1, mode_low = '1, b;
    logic [31:0] haddr_i = '0, hwdata_i = '0, hrdata_o, exp_q[$];
    logic [1:0] htrans_i = '0;
    logic [2:0] hsize_i = 3'h2;
    logic hreadyout_o, hresp_o, red_mode_n_o, red_mode_oe_o, green_sw1_n_o, green_sw1_oe_o;
    logic blue_n_o, rts_n_o, pullup_en_o, tx_permit_o, connect_req_o, serial_default_o;
    logic factory_restore_o, mode_strap_o, startup_done_o;
    logic [3:0] v;
    wire logic red_mode_n_i, green_sw1_n_i;
    int miscompares = 0, checked = 0, n, nf;
    always #50 clk_i = ~clk_i;
    status_led_strap_pins #(.CYC_PER_MS(MS)) dut (.clk_i, .rstn_i, .hsel_i, .haddr_i,
        .htrans_i, .hwrite_i, .hsize_i, .hready_i(hreadyout_o), .hwdata_i, .hrdata_o,
        .hreadyout_o, .hresp_o, .red_mode_n_i, .red_mode_n_o, .red_mode_oe_o, .green_sw1_n_i,
        .green_sw1_n_o, .green_sw1_oe_o, .switch0_n_i, .blue_n_o, .cts_n_i, .rts_n_o,
        .pullup_en_o, .traffic_i, .tx_permit_o, .connect_req_o, .serial_default_o,
        .factory_restore_o, .mode_strap_o, .startup_done_o);
    host_board board (.grn_low_i(grn_low), .mode_low_i(mode_low), .dev_grn_i(green_sw1_n_o),
        .dev_grn_oe_i(green_sw1_oe_o), .dev_red_i(red_mode_n_o), .dev_red_oe_i(red_mode_oe_o),
        .grn_pad_o(green_sw1_n_i), .red_pad_o(red_mode_n_i));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic give_verdict;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : give_verdict
    // bounded wait for bus ready or for start-up to finish
    task automatic wait_for(input int lim, input bit for_done);
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while ((for_done ? startup_done_o : hreadyout_o) !== 1'h1 && n < lim);
        if ((for_done ? startup_done_o : hreadyout_o) !== 1'h1) begin
            miscompares++;
            give_verdict();
        end
    endtask : wait_for
    task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
        hsel_i <= 1'h1;
        haddr_i <= a;
        hwrite_i <= w;
        htrans_i <= 2'h2;
        wait_for(16, 1'b0);
        htrans_i <= 2'h0;
        hwdata_i <= d;
        rd_dph <= ~w;
        wait_for(16, 1'b0);
        rd_dph <= 1'h0;
    endtask : bus
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(a, 1'h0, '0);
    endtask : rd
    always @(posedge clk_i) begin
        if (rd_dph && hreadyout_o === 1'h1)
            chk(hrdata_o, exp_q.pop_front(), "read data");
    end
    initial begin
        void'($urandom(32'h2452));
        repeat (12) @(posedge clk_i);
        rstn_i <= 1'h1;
        repeat (450 * MS) @(negedge clk_i);
        chk(green_sw1_oe_o, '0, "green oe early");
        chk(red_mode_oe_o, '0, "red oe early");
        repeat (100 * MS) @(negedge clk_i);
        chk(green_sw1_oe_o, 1'h1, "green oe");
        chk(red_mode_oe_o, '0, "red oe mid");
        chk(serial_default_o, 1'h1, "serial default");
        chk(factory_restore_o, 1'h1, "restore");
        wait_for(100 * MS, 1'b1);
        chk(mode_strap_o, 1'h1, "mode strap");
        chk(red_mode_oe_o, 1'h1, "red oe");
        switch0_n_i <= 1'h1;
        rd(EV_A, 32'h3);
        bus(STAT_A, 1'h1, '1);
        rd(32'h0c, '0);
        rd(STAT_A, 32'h4f);
        switch0_n_i <= 1'h0;
        repeat (3) @(posedge clk_i);
        @(negedge clk_i);
        chk(connect_req_o, 1'h1, "connect");
        @(posedge clk_i);
        rd(EV_A, 32'h7);
        bus(EV_A, 1'h1, 32'h7);
        rd(EV_A, '0);
        switch0_n_i <= 1'h1;
        for (int i = 0; i < 8; i++) begin
            v = 4'($urandom());
            cts_n_i <= 1'($urandom());
            bus(CTRL_A, 1'h1, {28'h0, v});
            rd(CTRL_A, {28'h0, v});
            @(negedge clk_i);
            chk(red_mode_n_o, !v[0], "red led");
            chk(green_sw1_n_o, !v[1], "green led");
            chk(blue_n_o, !v[2], "blue led");
            chk(rts_n_o, !v[3], "rts");
            chk(tx_permit_o, !cts_n_i, "tx permit");
            chk(connect_req_o, '0, "connect off");
            @(posedge clk_i);
        end
        bus(CTRL_A, 1'h1, '0);
        @(posedge clk_i);
        traffic_i <= 1'h1;
        @(posedge clk_i);
        traffic_i <= 1'h0;
        nf = 0;
        b = 1'h1;
        repeat (150 * MS) begin
            @(negedge clk_i);
            nf += int'(b && !blue_n_o);
            b = blue_n_o;
        end
        chk(nf != 0, 1'h1, "blink");
        chk(blue_n_o, 1'h1, "blue idle");
        // second start-up with both straps left to the pull-ups
        @(posedge clk_i);
        rstn_i <= 1'h0;
        grn_low <= 1'h0;
        mode_low <= 1'h0;
        repeat (12) @(posedge clk_i);
        rstn_i <= 1'h1;
        @(negedge clk_i);
        chk(green_sw1_oe_o, '0, "green oe after reset");
        wait_for(700 * MS, 1'b1);
        chk(serial_default_o, '0, "serial default idle");
        chk(mode_strap_o, '0, "mode idle");
        chk(factory_restore_o, '0, "no restore");
        give_verdict();
    end
endmodule : status_led_strap_pins_bench
`default_nettype wire
